// *** pcsi_pkg.sv ***
package pcsi_pkg;

    // Widths of the program flow and addressing datapaths
    localparam int PC_W = 13;
    localparam int LOW_W = 8;
    localparam int UPPER_W = 5;
    localparam int TGT_W = 11;
    localparam int STACK_DEPTH = 8;
    localparam int SP_W = 3;
    localparam int DADDR_W = 9;
    localparam int AXI_AW = 12;
    localparam int IDX_W = 10;

    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_INDIRECT = 10'h000;
    localparam logic [IDX_W-1:0] IDX_PC_LOW = 10'h002;
    localparam logic [IDX_W-1:0] IDX_STATUS = 10'h003;
    localparam logic [IDX_W-1:0] IDX_POINTER = 10'h004;
    localparam logic [IDX_W-1:0] IDX_UPPER_LATCH = 10'h00a;
    localparam logic [IDX_W-1:0] IDX_POWER_CONTROL = 10'h08e;

    // Field positions
    localparam int BANK_BIT = 7;
    localparam int POR_FLAG_BIT = 1;
    localparam int PAGE_HI_BIT = 4;
    localparam int PAGE_LO_BIT = 3;

    // Reset values and fixed codes
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
    localparam logic [SP_W-1:0] SP_RESET = 3'h0;
    localparam logic [SP_W-1:0] SP_ONE = 3'h1;
    localparam logic [UPPER_W-1:0] LATCH_RESET = 5'h00;
    localparam logic [LOW_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // One instruction's requests from the decoder, valid for one cycle
    typedef struct packed {
        logic fetch;
        logic pcl_wr;
        logic latch_wr;
        logic branch;
        logic is_call;
        logic irq;
        logic ret;
        logic ind_rd;
        logic ind_wr;
        logic [TGT_W-1:0] target;
        logic [LOW_W-1:0] wdata;
    } pcsi_cmd_t;

    // State shown back to the decoder
    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [LOW_W-1:0] ind_rdata;
        logic ind_rvalid;
    } pcsi_stat_t;

endpackage

// *** pcsi_core.sv ***
`timescale 1ns/100ps
`default_nettype none
module pcsi_core
    import pcsi_pkg::*;
#(
    parameter bit PAGE_BIT4_USED = 1'b0,
    parameter int DATA_DEPTH = 512
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic power_on_rst,
    // Decoder side
    input wire pcsi_cmd_t cmd,
    output pcsi_stat_t stat,
    // AXI4-Lite write
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    logic [PC_W-1:0] pc_q;
    logic [UPPER_W-1:0] latch_q;
    logic [LOW_W-1:0] ptr_q;
    logic bank_q;
    logic por_flag_q;
    logic [PC_W-1:0] stack_q [STACK_DEPTH];
    logic [SP_W-1:0] sp_q;
    logic [LOW_W-1:0] dmem_q [DATA_DEPTH];
    logic [LOW_W-1:0] ind_rdata_q;
    logic ind_rvalid_q;

    // AXI write capture
    logic aw_full_q;
    logic w_full_q;
    logic aw_free_q;
    logic w_free_q;
    logic [IDX_W-1:0] aw_idx_q;
    logic [LOW_W-1:0] w_byte_q;
    logic w_lane0_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    logic wr_go;
    logic [DADDR_W-1:0] ind_addr;
    logic [PC_W-1:0] page_hi;
    logic [PC_W-1:0] pcl_target;
    logic [PC_W-1:0] br_target;
    logic [IDX_W-1:0] ar_idx;
    logic sw_pcl_wr;
    logic sw_latch_wr;
    logic sw_ptr_wr;
    logic sw_bank_wr;
    logic sw_por_wr;
    logic sw_ind_wr;
    logic core_busy_pc;

    function automatic logic mapped(input logic [IDX_W-1:0] idx);
        mapped = (idx == IDX_INDIRECT) || (idx == IDX_PC_LOW) || (idx == IDX_STATUS) ||
                 (idx == IDX_POINTER) || (idx == IDX_UPPER_LATCH) || (idx == IDX_POWER_CONTROL);
    endfunction

    // Indirect address: bank bit above the pointer
    assign ind_addr = {bank_q, ptr_q};

    // Page bits; bit four is dropped on this variant
    always_comb begin
        page_hi = PC_RESET;
        page_hi[PC_W-1] = PAGE_BIT4_USED & latch_q[PAGE_HI_BIT];
        page_hi[PC_W-2] = latch_q[PAGE_LO_BIT];
    end

    always_comb begin
        pcl_target = {page_hi[PC_W-1], latch_q[UPPER_W-2:0], BYTE_ZERO};
        if (cmd.pcl_wr) begin
            pcl_target[LOW_W-1:0] = cmd.wdata;
        end else begin
            pcl_target[LOW_W-1:0] = w_byte_q;
        end
    end

    assign br_target = {page_hi[PC_W-1:PC_W-2], cmd.target};

    // Software register writes
    assign wr_go = aw_full_q && w_full_q && !bvalid_q;
    assign sw_pcl_wr = wr_go && w_lane0_q && (aw_idx_q == IDX_PC_LOW);
    assign sw_latch_wr = wr_go && w_lane0_q && (aw_idx_q == IDX_UPPER_LATCH);
    assign sw_ptr_wr = wr_go && w_lane0_q && (aw_idx_q == IDX_POINTER);
    assign sw_bank_wr = wr_go && w_lane0_q && (aw_idx_q == IDX_STATUS);
    assign sw_por_wr = wr_go && w_lane0_q && (aw_idx_q == IDX_POWER_CONTROL);
    assign sw_ind_wr = wr_go && w_lane0_q && (aw_idx_q == IDX_INDIRECT);
    assign core_busy_pc = cmd.irq || cmd.ret || cmd.branch || cmd.pcl_wr;

    // Program counter: interrupt, return, branch, low write, fetch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pc_q <= PC_RESET;
        end else if (cmd.irq) begin
            pc_q <= IRQ_VECTOR;
        end else if (cmd.ret) begin
            pc_q <= stack_q[sp_q - SP_ONE];
        end else if (cmd.branch) begin
            pc_q <= br_target;
        end else if (cmd.pcl_wr || sw_pcl_wr) begin
            pc_q <= pcl_target;
        end else if (cmd.fetch) begin
            pc_q <= pc_q + PC_ONE;
        end
    end

    // Return stack; pointer is internal only and wraps freely
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sp_q <= SP_RESET;
        end else if (cmd.irq || (cmd.branch && cmd.is_call)) begin
            stack_q[sp_q] <= pc_q;
            sp_q <= sp_q + SP_ONE;
        end else if (cmd.ret) begin
            sp_q <= sp_q - SP_ONE;
        end
    end

    // Upper latch; stack traffic does not touch it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch_q <= LATCH_RESET;
        end else if (cmd.latch_wr) begin
            latch_q <= cmd.wdata[UPPER_W-1:0];
        end else if (sw_latch_wr) begin
            latch_q <= w_byte_q[UPPER_W-1:0];
        end
    end

    // Pointer and bank bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ptr_q <= BYTE_ZERO;
            bank_q <= 1'b0;
        end else begin
            if (sw_ptr_wr) begin
                ptr_q <= w_byte_q;
            end
            if (sw_bank_wr) begin
                bank_q <= w_byte_q[BANK_BIT];
            end
        end
    end

    // Power-on flag: cleared by power-on reset, not by pin reset alone; written by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            if (power_on_rst) begin
                por_flag_q <= 1'b0;
            end
        end else if (sw_por_wr) begin
            por_flag_q <= w_byte_q[POR_FLAG_BIT];
        end
    end

    // Data registers reached through the indirect register
    always_ff @(posedge aclk) begin
        if (ptr_q != BYTE_ZERO) begin
            if (cmd.ind_wr) begin
                dmem_q[ind_addr] <= cmd.wdata;
            end else if (sw_ind_wr) begin
                dmem_q[ind_addr] <= w_byte_q;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ind_rdata_q <= BYTE_ZERO;
            ind_rvalid_q <= 1'b0;
        end else begin
            ind_rvalid_q <= cmd.ind_rd;
            if (cmd.ind_rd) begin
                ind_rdata_q <= (ptr_q == BYTE_ZERO) ? BYTE_ZERO : dmem_q[ind_addr];
            end
        end
    end

    assign stat.pc = pc_q;
    assign stat.ind_rdata = ind_rdata_q;
    assign stat.ind_rvalid = ind_rvalid_q;

    // AXI write: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_free_q <= 1'b1;
            w_free_q <= 1'b1;
            aw_idx_q <= IDX_INDIRECT;
            w_byte_q <= BYTE_ZERO;
            w_lane0_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && !aw_full_q) begin
                aw_full_q <= 1'b1;
                aw_free_q <= 1'b0;
                aw_idx_q <= s_axi_awaddr[AXI_AW-1:2];
            end else if (wr_go) begin
                aw_full_q <= 1'b0;
                aw_free_q <= 1'b1;
            end
            if (s_axi_wvalid && !w_full_q) begin
                w_full_q <= 1'b1;
                w_free_q <= 1'b0;
                w_byte_q <= s_axi_wdata[LOW_W-1:0];
                w_lane0_q <= s_axi_wstrb[0];
            end else if (wr_go) begin
                w_full_q <= 1'b0;
                w_free_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= mapped(aw_idx_q) ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Ready flags kept as flops, the inverse of the capture flags
    assign s_axi_awready = aw_free_q;
    assign s_axi_wready = w_free_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // AXI read: one beat, answered the cycle after acceptance
    assign ar_idx = s_axi_araddr[AXI_AW-1:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= WORD_ZERO;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rresp_q <= mapped(ar_idx) ? RESP_OKAY : RESP_DECERR;
            rdata_q <= WORD_ZERO;
            unique case (ar_idx)
                IDX_PC_LOW: rdata_q[LOW_W-1:0] <= pc_q[LOW_W-1:0];
                IDX_UPPER_LATCH: rdata_q[UPPER_W-1:0] <= latch_q;
                IDX_POINTER: rdata_q[LOW_W-1:0] <= ptr_q;
                IDX_STATUS: rdata_q[BANK_BIT] <= bank_q;
                IDX_POWER_CONTROL: rdata_q[POR_FLAG_BIT] <= por_flag_q;
                IDX_INDIRECT: begin
                    if (ptr_q != BYTE_ZERO) begin
                        rdata_q[LOW_W-1:0] <= dmem_q[ind_addr];
                    end
                end
                default: rdata_q <= WORD_ZERO;
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Checks
    property p_reset_clear;
        @(posedge aclk) !aresetn |=> (pc_q == PC_RESET);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("pc not cleared by reset");

    property p_fetch_inc;
        @(posedge aclk) disable iff (!aresetn)
            (cmd.fetch && !core_busy_pc && !sw_pcl_wr) |=> (pc_q == $past(pc_q) + PC_ONE);
    endproperty
    a_fetch_inc: assert property (p_fetch_inc) else $error("fetch did not advance pc");

    property p_pcl_load;
        @(posedge aclk) disable iff (!aresetn)
            (cmd.pcl_wr && !cmd.irq && !cmd.ret && !cmd.branch) |=>
            (pc_q[PC_W-2:LOW_W] == $past(latch_q[UPPER_W-2:0])) && (pc_q[LOW_W-1:0] == $past(cmd.wdata));
    endproperty
    a_pcl_load: assert property (p_pcl_load) else $error("low write did not load latch bits");

    property p_branch_page;
        @(posedge aclk) disable iff (!aresetn)
            (cmd.branch && !cmd.irq && !cmd.ret) |=>
            (pc_q[TGT_W-1:0] == $past(cmd.target)) && (pc_q[PC_W-2] == $past(latch_q[PAGE_LO_BIT]));
    endproperty
    a_branch_page: assert property (p_branch_page) else $error("branch target wrong");

    property p_bit4_ignored;
        @(posedge aclk) disable iff (!aresetn)
            !PAGE_BIT4_USED |-> (pc_q[PC_W-1] == 1'b0);
    endproperty
    a_bit4_ignored: assert property (p_bit4_ignored) else $error("page bit four used");

    property p_call_return;
        @(posedge aclk) disable iff (!aresetn)
            (cmd.branch && cmd.is_call && !cmd.irq && !cmd.ret) ##1 (cmd.ret && !cmd.irq)
            |=> (pc_q == $past(pc_q, 2));
    endproperty
    a_call_return: assert property (p_call_return) else $error("return lost call address");

    property p_latch_kept;
        @(posedge aclk) disable iff (!aresetn)
            ((cmd.irq || cmd.ret) && !cmd.latch_wr && !sw_latch_wr) |=> $stable(latch_q);
    endproperty
    a_latch_kept: assert property (p_latch_kept) else $error("stack op changed latch");

    property p_sp_wrap;
        @(posedge aclk) disable iff (!aresetn)
            (cmd.irq || (cmd.branch && cmd.is_call)) |=> (sp_q == $past(sp_q) + SP_ONE);
    endproperty
    a_sp_wrap: assert property (p_sp_wrap) else $error("push pointer step wrong");

    property p_zero_read;
        @(posedge aclk) disable iff (!aresetn)
            (cmd.ind_rd && ptr_q == BYTE_ZERO) |=> (ind_rvalid_q && ind_rdata_q == BYTE_ZERO);
    endproperty
    a_zero_read: assert property (p_zero_read) else $error("zero pointer read not zero");

    property p_por_flag;
        @(posedge aclk) (!aresetn && power_on_rst) |=> (por_flag_q == 1'b0);
    endproperty
    a_por_flag: assert property (p_por_flag) else $error("power-on flag not cleared");

    property p_bresp_order;
        @(posedge aclk) disable iff (!aresetn)
            wr_go |=> s_axi_bvalid;
    endproperty
    a_bresp_order: assert property (p_bresp_order) else $error("write answer missing");

endmodule
`default_nettype wire

// *** pcsi_decoder_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pcsi_decoder_model
    import pcsi_pkg::*;
(
    // Clock
    input wire logic aclk,
    // Requests to the core
    output var pcsi_cmd_t cmd
);
    // Request flags, in field order of the command
    localparam logic [8:0] OP_FETCH = 9'h100;
    localparam logic [8:0] OP_PCL = 9'h080;
    localparam logic [8:0] OP_LATCH = 9'h040;
    localparam logic [8:0] OP_JUMP = 9'h020;
    localparam logic [8:0] OP_CALL = 9'h030;
    localparam logic [8:0] OP_IRQ = 9'h008;
    localparam logic [8:0] OP_RET = 9'h004;
    localparam logic [8:0] OP_IRD = 9'h002;
    localparam logic [8:0] OP_IWR = 9'h001;

    initial cmd = '0;

    // One-cycle request; returns once the core has taken it
    task automatic op(input logic [8:0] f, input logic [10:0] t, input logic [7:0] d);
        @(posedge aclk);
        cmd <= pcsi_cmd_t'({f, t, d});
        @(posedge aclk);
        cmd <= '0;
        #1;
    endtask

    // Two requests on consecutive edges, no idle cycle between
    task automatic op_pair(input logic [8:0] f1, input logic [10:0] t1, input logic [8:0] f2);
        @(posedge aclk);
        cmd <= pcsi_cmd_t'({f1, t1, 8'h00});
        @(posedge aclk);
        cmd <= pcsi_cmd_t'({f2, 11'h000, 8'h00});
        @(posedge aclk);
        cmd <= '0;
        #1;
    endtask

    // Page bits go in first so the branch lands in the wanted page
    task automatic branch_to(input logic [4:0] page, input logic [10:0] t, input logic call);
        op(OP_LATCH, 11'h000, {3'h0, page});
        op(call ? OP_CALL : OP_JUMP, t, 8'h00);
    endtask

    // Upper bits of a table jump come from the latch, so set them first
    task automatic table_jump(input logic [4:0] upper, input logic [7:0] low);
        op(OP_LATCH, 11'h000, {3'h0, upper});
        op(OP_PCL, 11'h000, low);
    endtask
endmodule
`default_nettype wire

// *** program_counter_stack_indirect_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module program_counter_stack_indirect_tb
    import pcsi_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic power_on_rst = 1'b1;
    pcsi_cmd_t cmd;
    pcsi_stat_t stat;
    logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [PC_W-1:0] stk [STACK_DEPTH];
    logic [PC_W-1:0] pc_e;
    logic [SP_W-1:0] sp;
    int i;
    int n_mismatch = 0;
    int cmp_count = 0;

    always #4 aclk = ~aclk;

    pcsi_core #(.PAGE_BIT4_USED(1'b0), .DATA_DEPTH(512)) i_dut (
        .aclk, .aresetn, .power_on_rst, .cmd, .stat,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );

    pcsi_decoder_model i_dec (.aclk, .cmd);

    task automatic print_verdict;
        $display("Compares %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic give_up;
        n_mismatch++;
        $display("[FAIL] bus handshake expected answer seen timeout");
        print_verdict();
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bit 12 never comes from the latch in this variant
    function automatic logic [PC_W-1:0] tgt_pc(input logic [4:0] lat, input logic [10:0] t);
        return {1'b0, lat[PAGE_LO_BIT], t};
    endfunction

    task automatic axi_write(input logic [IDX_W-1:0] idx, input logic [7:0] d, input logic [1:0] rsp);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 50) give_up();
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(rsp), 32'(s_axi_bresp));
        #1;
    endtask

    task automatic axi_read(input logic [IDX_W-1:0] idx, input logic [31:0] exp, input logic [31:0] msk,
                            input logic [1:0] rsp, input string what);
        int n;
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 50) give_up();
        s_axi_rready <= 1'b0;
        chk(what, exp, s_axi_rdata & msk);
        chk("rresp", 32'(rsp), 32'(s_axi_rresp));
        #1;
    endtask

    task automatic do_reset(input logic por);
        @(posedge aclk);
        aresetn <= 1'b0;
        power_on_rst <= por;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        power_on_rst <= 1'b0;
        #1;
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        power_on_rst <= 1'b0;
        #1;
        chk("pc after reset", 32'h0, 32'(stat.pc));
        axi_read(IDX_POWER_CONTROL, 32'h0, 32'h2, RESP_OKAY, "power flag");
        axi_write(IDX_POWER_CONTROL, 8'h02, RESP_OKAY);
        repeat (3) i_dec.op(i_dec.OP_FETCH, 11'h000, 8'h00);
        chk("pc after fetches", 32'h3, 32'(stat.pc));
        $display("test reset_fetch done");

        i_dec.table_jump(5'h1d, 8'h5a);
        chk("pc after low write", 32'h0d5a, 32'(stat.pc));
        axi_read(IDX_PC_LOW, 32'h5a, 32'hffffffff, RESP_OKAY, "pc low");
        axi_read(IDX_UPPER_LATCH, 32'h1d, 32'h1f, RESP_OKAY, "latch");
        i_dec.table_jump(5'h02, 8'hff);
        i_dec.op(i_dec.OP_FETCH, 11'h000, 8'h00);
        chk("pc over byte edge", 32'h0300, 32'(stat.pc));
        axi_write(IDX_PC_LOW, 8'h44, RESP_OKAY);
        chk("pc after bus low write", 32'h0244, 32'(stat.pc));
        $display("test low_byte done");

        i_dec.branch_to(5'h18, 11'h123, 1'b0);
        chk("jump page", 32'(tgt_pc(5'h18, 11'h123)), 32'(stat.pc));
        i_dec.branch_to(5'h10, 11'h7ff, 1'b0);
        chk("jump page bit4", 32'h07ff, 32'(stat.pc));
        $display("test paging done");

        pc_e = stat.pc;
        sp = SP_RESET;
        for (i = 0; i < 9; i++) begin
            stk[sp] = pc_e;
            sp = sp + SP_ONE;
            if (i == 4) begin
                pc_e = IRQ_VECTOR;
                i_dec.op(i_dec.OP_IRQ, 11'h000, 8'h00);
            end else begin
                pc_e = tgt_pc(5'h08, 11'h100 + 11'(i));
                i_dec.branch_to(5'h08, 11'h100 + 11'(i), 1'b1);
            end
            chk("pc after push", 32'(pc_e), 32'(stat.pc));
        end
        i_dec.op(i_dec.OP_LATCH, 11'h000, 8'h15);
        for (i = 0; i < 9; i++) begin
            sp = sp - SP_ONE;
            i_dec.op(i_dec.OP_RET, 11'h000, 8'h00);
            chk("pc after pop", 32'(stk[sp]), 32'(stat.pc));
        end
        axi_read(IDX_UPPER_LATCH, 32'h15, 32'h1f, RESP_OKAY, "latch after pops");
        pc_e = stat.pc;
        i_dec.op_pair(i_dec.OP_CALL, 11'h055, i_dec.OP_RET);
        chk("pc after call then return", 32'(pc_e), 32'(stat.pc));
        $display("test stack done");

        axi_write(IDX_POINTER, 8'h10, RESP_OKAY);
        axi_write(IDX_STATUS, 8'h80, RESP_OKAY);
        axi_read(IDX_STATUS, 32'h80, 32'hffffffff, RESP_OKAY, "bank bit");
        i_dec.op(i_dec.OP_IWR, 11'h000, 8'ha5);
        axi_write(IDX_STATUS, 8'h00, RESP_OKAY);
        i_dec.op(i_dec.OP_IWR, 11'h000, 8'h3c);
        i_dec.op(i_dec.OP_IRD, 11'h000, 8'h00);
        chk("ind read bank0", 32'h13c, {23'h0, stat.ind_rvalid, stat.ind_rdata});
        axi_write(IDX_STATUS, 8'h80, RESP_OKAY);
        i_dec.op(i_dec.OP_IRD, 11'h000, 8'h00);
        chk("ind read bank1", 32'h1a5, {23'h0, stat.ind_rvalid, stat.ind_rdata});
        @(posedge aclk);
        #1;
        chk("ind valid drop", 32'h0, 32'(stat.ind_rvalid));
        axi_read(IDX_INDIRECT, 32'ha5, 32'hffffffff, RESP_OKAY, "bus indirect");
        axi_write(IDX_POINTER, 8'h00, RESP_OKAY);
        i_dec.op(i_dec.OP_IWR, 11'h000, 8'h77);
        i_dec.op(i_dec.OP_IRD, 11'h000, 8'h00);
        chk("ind read ptr0", 32'h100, {23'h0, stat.ind_rvalid, stat.ind_rdata});
        axi_read(IDX_INDIRECT, 32'h0, 32'hffffffff, RESP_OKAY, "bus indirect ptr0");
        axi_write(IDX_POINTER, 8'h10, RESP_OKAY);
        axi_read(IDX_INDIRECT, 32'ha5, 32'hffffffff, RESP_OKAY, "data kept");
        axi_write(IDX_INDIRECT, 8'h6b, RESP_OKAY);
        axi_read(IDX_INDIRECT, 32'h6b, 32'hffffffff, RESP_OKAY, "bus indirect write");
        $display("test indirect done");

        axi_read(10'h3ff, 32'h0, 32'hffffffff, RESP_DECERR, "unmapped read");
        axi_write(10'h3fe, 8'h55, RESP_DECERR);
        do_reset(1'b0);
        chk("pc after pin reset", 32'h0, 32'(stat.pc));
        axi_read(IDX_POWER_CONTROL, 32'h2, 32'h2, RESP_OKAY, "flag kept");
        do_reset(1'b1);
        axi_read(IDX_POWER_CONTROL, 32'h0, 32'h2, RESP_OKAY, "flag on power-on");
        $display("test bus_reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
